/* File: rtl/mspc_accel_decode.v */
`timescale 1ns/100ps
`include "mspc_defs.vh"

// Start-up acceleration tables, purely combinational
module mspc_accel_decode (
   // Fields
   input  wire        scale_slow,
   input  wire [2:0]  accel2_code,
   input  wire [2:0]  accel1_code,
   // Decoded rates
   output reg  [19:0] accel2_rate,
   output reg  [16:0] accel1_rate
);

   // Second-order table; top code forces zero with either scale bit
   always @* begin
      case ({scale_slow, accel2_code})
         4'h0: accel2_rate = `MSPC_A2_F0;
         4'h1: accel2_rate = `MSPC_A2_F1;
         4'h2: accel2_rate = `MSPC_A2_F2;
         4'h3: accel2_rate = `MSPC_A2_F3;
         4'h4: accel2_rate = `MSPC_A2_F4;
         4'h5: accel2_rate = `MSPC_A2_F5;
         4'h6: accel2_rate = `MSPC_A2_F6;
         4'h8: accel2_rate = `MSPC_A2_S0;
         4'h9: accel2_rate = `MSPC_A2_S1;
         4'hA: accel2_rate = `MSPC_A2_S2;
         4'hB: accel2_rate = `MSPC_A2_S3;
         4'hC: accel2_rate = `MSPC_A2_S4;
         4'hD: accel2_rate = `MSPC_A2_S5;
         4'hE: accel2_rate = `MSPC_A2_S6;
         default: accel2_rate = `MSPC_A2_ZERO;
      endcase
   end

   // First-order table, rate falls as the code rises
   always @* begin
      case ({scale_slow, accel1_code})
         4'h0: accel1_rate = `MSPC_A1_F0;
         4'h1: accel1_rate = `MSPC_A1_F1;
         4'h2: accel1_rate = `MSPC_A1_F2;
         4'h3: accel1_rate = `MSPC_A1_F3;
         4'h4: accel1_rate = `MSPC_A1_F4;
         4'h5: accel1_rate = `MSPC_A1_F5;
         4'h6: accel1_rate = `MSPC_A1_F6;
         4'h7: accel1_rate = `MSPC_A1_F7;
         4'h8: accel1_rate = `MSPC_A1_S0;
         4'h9: accel1_rate = `MSPC_A1_S1;
         4'hA: accel1_rate = `MSPC_A1_S2;
         4'hB: accel1_rate = `MSPC_A1_S3;
         4'hC: accel1_rate = `MSPC_A1_S4;
         4'hD: accel1_rate = `MSPC_A1_S5;
         4'hE: accel1_rate = `MSPC_A1_S6;
         default: accel1_rate = `MSPC_A1_S7;
      endcase
   end

endmodule

/* File: rtl/mspc_config_top.v */
// Function
// - Scale bit picks fast or slow table
// - Second-order code selects halving quadratic rate
// - Second-order code 111 gives zero acceleration
// - First-order code selects falling linear rate
// - Low range: handover speed n times 0.8Hz
// - High range: 12.8Hz times (n-16) plus 11.9Hz
// - Alignment time 5.3s halving to 0.04s
// - Overtemp cap none, 1A, 1.6A, 2A
// - Bit 13 enables closed-loop stuck detection
// - Bit 12 enables open-loop stuck detection
// - Bit 11 enables no-motor fault detection
// - Bit 10 enables torque constant fault detection
// - Bit 9 enables abnormal speed detection
// - Bit 8 enables current lock detection
// - Acceleration cap off at zero, else n*0.2A
// - Range 0 lock cap table, top bit ignored
// - Range 1 lock cap 0.4A steps to 3.2A
// - Bit 0 selects lock cap range
// - Protection register at 0x94, reset zero, RW
`timescale 1ns/100ps
`include "mspc_defs.vh"

module mspc_config_top (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_b,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   output reg         reg_rd_valid,
   output reg         reg_miss,
   // Start-up profile settings
   output reg  [19:0] accel2_rate,
   output reg  [16:0] accel1_rate,
   output reg  [10:0] handover_speed,
   output reg         handover_valid,
   output reg  [12:0] align_time_ms,
   // Protection settings
   output reg  [11:0] overtemp_cap_ma,
   output reg         overtemp_cap_en,
   output reg  [11:0] accel_cap_ma,
   output reg         accel_cap_en,
   output reg  [11:0] lock_cap_ma,
   output reg         closed_loop_stuck_detect_en,
   output reg         open_loop_stuck_detect_en,
   output reg         no_motor_detect_en,
   output reg         torque_const_fault_detect_en,
   output reg         speed_fault_detect_en,
   output reg         current_lock_detect_en
);

   // Address decode, used by both the write and the read path
   function addr_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // Alignment time, each code roughly halves the time
   function [12:0] align_lookup;
      input [2:0] code;
      begin
         case (code)
            3'h0: align_lookup = `MSPC_AL_0;
            3'h1: align_lookup = `MSPC_AL_1;
            3'h2: align_lookup = `MSPC_AL_2;
            3'h3: align_lookup = `MSPC_AL_3;
            3'h4: align_lookup = `MSPC_AL_4;
            3'h5: align_lookup = `MSPC_AL_5;
            3'h6: align_lookup = `MSPC_AL_6;
            default: align_lookup = `MSPC_AL_7;
         endcase
      end
   endfunction

   // Stored registers
   reg  [15:0] startup_profile_config;
   reg  [15:0] protection_limit_config;

   // Field views
   wire        accel_scale_select;
   wire [2:0]  startup_accel_second_order;
   wire [2:0]  startup_accel_first_order;
   wire [4:0]  open_to_closed_speed_threshold;
   wire [2:0]  rotor_align_duration;
   wire [1:0]  overtemp_current_cap;
   wire [5:0]  lock_detect_en;
   wire [3:0]  accel_current_cap;
   wire [2:0]  lock_current_cap;
   wire        lock_cap_range_select;

   // Combinational decode results
   wire [19:0] next_accel2_rate;
   wire [16:0] next_accel1_rate;
   wire [11:0] next_overtemp_cap_ma;
   wire        next_overtemp_cap_en;
   wire [11:0] next_accel_cap_ma;
   wire        next_accel_cap_en;
   wire [11:0] next_lock_cap_ma;
   reg  [10:0] next_handover_speed;
   wire [15:0] next_rdata;
   wire        hit_startup;
   wire        hit_protect;
   wire [10:0] thr_low_bits;

   assign hit_startup = addr_hit(reg_addr, `MSPC_ADDR_STARTUP);
   assign hit_protect = addr_hit(reg_addr, `MSPC_ADDR_PROTECT);

   // Field slices of the start-up register
   assign accel_scale_select         = startup_profile_config[
                                          `MSPC_SU_SCALE_BIT];
   assign startup_accel_second_order = startup_profile_config[
                                          `MSPC_SU_ACC2_HI:`MSPC_SU_ACC2_LO];
   assign startup_accel_first_order  = startup_profile_config[
                                          `MSPC_SU_ACC1_HI:`MSPC_SU_ACC1_LO];
   assign open_to_closed_speed_threshold = startup_profile_config[
                                          `MSPC_SU_THR_HI:`MSPC_SU_THR_LO];
   assign rotor_align_duration       = startup_profile_config[
                                          `MSPC_SU_ALIGN_HI:`MSPC_SU_ALIGN_LO];

   // Field slices of the protection register
   assign overtemp_current_cap  = protection_limit_config[
                                     `MSPC_PR_OT_HI:`MSPC_PR_OT_LO];
   assign lock_detect_en        = protection_limit_config[
                                     `MSPC_PR_LOCK_HI:`MSPC_PR_LOCK_LO];
   assign accel_current_cap     = protection_limit_config[
                                     `MSPC_PR_ACC_HI:`MSPC_PR_ACC_LO];
   assign lock_current_cap      = protection_limit_config[
                                     `MSPC_PR_LCAP_HI:`MSPC_PR_LCAP_LO];
   assign lock_cap_range_select = protection_limit_config[
                                     `MSPC_PR_RANGE_BIT];

   // Register writes; the reserved top start-up bit never stores a one
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         startup_profile_config  <= `MSPC_RST_STARTUP;
         protection_limit_config <= `MSPC_RST_PROTECT;
      end else if (reg_wr) begin
         if (hit_startup) begin
            startup_profile_config <= reg_wdata & `MSPC_SU_WR_MASK;
         end
         if (hit_protect) begin
            protection_limit_config <= reg_wdata;
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   assign next_rdata = hit_startup ? startup_profile_config :
                       hit_protect ? protection_limit_config :
                       16'h0000;

   // Read answer one cycle after the request, with a miss flag
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata    <= 16'h0000;
         reg_rd_valid <= 1'b0;
         reg_miss     <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         reg_miss     <= (reg_rd | reg_wr) & ~hit_startup & ~hit_protect;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // Acceleration tables
   mspc_accel_decode u_accel (
      .scale_slow  (accel_scale_select),
      .accel2_code (startup_accel_second_order),
      .accel1_code (startup_accel_first_order),
      .accel2_rate (next_accel2_rate),
      .accel1_rate (next_accel1_rate)
   );

   // Current caps
   mspc_current_decode u_current (
      .overtemp_current_cap  (overtemp_current_cap),
      .accel_current_cap     (accel_current_cap),
      .lock_current_cap      (lock_current_cap),
      .lock_cap_range_select (lock_cap_range_select),
      .overtemp_cap_ma       (next_overtemp_cap_ma),
      .overtemp_cap_en       (next_overtemp_cap_en),
      .accel_cap_ma          (next_accel_cap_ma),
      .accel_cap_en          (next_accel_cap_en),
      .lock_cap_ma           (next_lock_cap_ma)
   );

   assign thr_low_bits = {7'h00, open_to_closed_speed_threshold[3:0]};

   // Handover speed in 0.1 Hz; the high range has a coarser step
   always @* begin
      if (open_to_closed_speed_threshold[4]) begin
         next_handover_speed = thr_low_bits * `MSPC_THR_STEP_HI
                               + `MSPC_THR_BASE_HI;
      end else begin
         next_handover_speed = thr_low_bits * `MSPC_THR_STEP_LO;
      end
   end

   // Decoded settings are registered so outputs change one cycle after
   // the stored register, keeping the control loop glitch free
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         accel2_rate    <= `MSPC_A2_F0;
         accel1_rate    <= `MSPC_A1_F0;
         handover_speed <= 11'h000;
         handover_valid <= 1'b0;
         align_time_ms  <= `MSPC_AL_0;
      end else begin
         accel2_rate    <= next_accel2_rate;
         accel1_rate    <= next_accel1_rate;
         handover_speed <= next_handover_speed;
         // Zero in the low range is no usable handover speed
         handover_valid <= (open_to_closed_speed_threshold != 5'h00);
         align_time_ms  <= align_lookup(rotor_align_duration);
      end
   end

   // Protection outputs, same one-cycle latency
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         overtemp_cap_ma <= 12'h000;
         overtemp_cap_en <= 1'b0;
         accel_cap_ma    <= 12'h000;
         accel_cap_en    <= 1'b0;
         lock_cap_ma     <= `MSPC_LK_R0_0;
      end else begin
         overtemp_cap_ma <= next_overtemp_cap_ma;
         overtemp_cap_en <= next_overtemp_cap_en;
         accel_cap_ma    <= next_accel_cap_ma;
         accel_cap_en    <= next_accel_cap_en;
         lock_cap_ma     <= next_lock_cap_ma;
      end
   end

   // Lock detection enables, one bit each
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         closed_loop_stuck_detect_en  <= 1'b0;
         open_loop_stuck_detect_en    <= 1'b0;
         no_motor_detect_en           <= 1'b0;
         torque_const_fault_detect_en <= 1'b0;
         speed_fault_detect_en        <= 1'b0;
         current_lock_detect_en       <= 1'b0;
      end else begin
         closed_loop_stuck_detect_en  <= lock_detect_en[5];
         open_loop_stuck_detect_en    <= lock_detect_en[4];
         no_motor_detect_en           <= lock_detect_en[3];
         torque_const_fault_detect_en <= lock_detect_en[2];
         speed_fault_detect_en        <= lock_detect_en[1];
         current_lock_detect_en       <= lock_detect_en[0];
      end
   end

endmodule

/* File: rtl/mspc_current_decode.v */
`timescale 1ns/100ps
`include "mspc_defs.vh"

// Current caps of the protection register, combinational
module mspc_current_decode (
   // Fields
   input  wire [1:0]  overtemp_current_cap,
   input  wire [3:0]  accel_current_cap,
   input  wire [2:0]  lock_current_cap,
   input  wire        lock_cap_range_select,
   // Decoded limits in mA
   output reg  [11:0] overtemp_cap_ma,
   output wire        overtemp_cap_en,
   output wire [11:0] accel_cap_ma,
   output wire        accel_cap_en,
   output reg  [11:0] lock_cap_ma
);

   wire [15:0] accel_prod;
   wire [11:0] lock_steps;

   // Overtemperature cap; code zero defers to the acceleration cap
   always @* begin
      case (overtemp_current_cap)
         2'h1: overtemp_cap_ma = `MSPC_OT_1;
         2'h2: overtemp_cap_ma = `MSPC_OT_2;
         2'h3: overtemp_cap_ma = `MSPC_OT_3;
         default: overtemp_cap_ma = accel_cap_ma;
      endcase
   end
   assign overtemp_cap_en = (overtemp_current_cap != 2'h0);

   // Acceleration cap is n steps of 0.2 A, zero disables it
   assign accel_prod   = accel_current_cap * `MSPC_ACC_STEP;
   assign accel_cap_ma = accel_prod[11:0];
   assign accel_cap_en = (accel_current_cap != 4'h0);

   // Lock cap: table range ignores the top bit, linear range does not
   assign lock_steps = {9'h000, lock_current_cap} + 12'h001;
   always @* begin
      if (lock_cap_range_select) begin
         lock_cap_ma = lock_steps * `MSPC_LK_R1_STEP;
      end else begin
         case (lock_current_cap[1:0])
            2'h0: lock_cap_ma = `MSPC_LK_R0_0;
            2'h1: lock_cap_ma = `MSPC_LK_R0_1;
            2'h2: lock_cap_ma = `MSPC_LK_R0_2;
            default: lock_cap_ma = `MSPC_LK_R0_3;
         endcase
      end
   end

endmodule

/* File: rtl/mspc_defs.vh */
`ifndef MSPC_DEFS_VH
`define MSPC_DEFS_VH

// Register offsets on the register port
`define MSPC_ADDR_STARTUP      8'h93
`define MSPC_ADDR_PROTECT      8'h94

// Reset values
`define MSPC_RST_STARTUP       16'h0000
`define MSPC_RST_PROTECT       16'h0000

// Start-up profile register fields
`define MSPC_SU_RSVD_BIT       15
`define MSPC_SU_SCALE_BIT      14
`define MSPC_SU_ACC2_HI        13
`define MSPC_SU_ACC2_LO        11
`define MSPC_SU_ACC1_HI        10
`define MSPC_SU_ACC1_LO        8
`define MSPC_SU_THR_HI         7
`define MSPC_SU_THR_LO         3
`define MSPC_SU_ALIGN_HI       2
`define MSPC_SU_ALIGN_LO       0
`define MSPC_SU_WR_MASK        16'h7FFF

// Protection register fields
`define MSPC_PR_OT_HI          15
`define MSPC_PR_OT_LO          14
`define MSPC_PR_LOCK_HI        13
`define MSPC_PR_LOCK_LO        8
`define MSPC_PR_ACC_HI         7
`define MSPC_PR_ACC_LO         4
`define MSPC_PR_LCAP_HI        3
`define MSPC_PR_LCAP_LO        1
`define MSPC_PR_RANGE_BIT      0

// Second-order rate, units of 0.0001 Hz/s^2, fast then slow table
`define MSPC_A2_F0 20'h8B290
`define MSPC_A2_F1 20'h46CD0
`define MSPC_A2_F2 20'h222E0
`define MSPC_A2_F3 20'h10D88
`define MSPC_A2_F4 20'h080E8
`define MSPC_A2_F5 20'h03E80
`define MSPC_A2_F6 20'h01F40
`define MSPC_A2_S0 20'h00898
`define MSPC_A2_S1 20'h0044C
`define MSPC_A2_S2 20'h00226
`define MSPC_A2_S3 20'h0010E
`define MSPC_A2_S4 20'h00082
`define MSPC_A2_S5 20'h0003F
`define MSPC_A2_S6 20'h0001F
`define MSPC_A2_ZERO 20'h00000

// First-order rate, units of 0.001 Hz/s, fast then slow table
`define MSPC_A1_F0 17'h128E0
`define MSPC_A1_F1 17'h09470
`define MSPC_A1_F2 17'h04A38
`define MSPC_A1_F3 17'h023F0
`define MSPC_A1_F4 17'h01194
`define MSPC_A1_F5 17'h00834
`define MSPC_A1_F6 17'h00384
`define MSPC_A1_F7 17'h0012C
`define MSPC_A1_S0 17'h012C0
`define MSPC_A1_S1 17'h00960
`define MSPC_A1_S2 17'h004B0
`define MSPC_A1_S3 17'h00244
`define MSPC_A1_S4 17'h00118
`define MSPC_A1_S5 17'h00082
`define MSPC_A1_S6 17'h00038
`define MSPC_A1_S7 17'h00013

// Handover speed, units of 0.1 Hz
`define MSPC_THR_STEP_LO  11'h008
`define MSPC_THR_STEP_HI  11'h080
`define MSPC_THR_BASE_HI  11'h077

// Alignment time, units of 1 ms
`define MSPC_AL_0 13'h14B4
`define MSPC_AL_1 13'h0A8C
`define MSPC_AL_2 13'h0514
`define MSPC_AL_3 13'h029E
`define MSPC_AL_4 13'h014A
`define MSPC_AL_5 13'h00A0
`define MSPC_AL_6 13'h0050
`define MSPC_AL_7 13'h0028

// Currents, units of 1 mA
`define MSPC_OT_1  12'h3E8
`define MSPC_OT_2  12'h640
`define MSPC_OT_3  12'h7D0
`define MSPC_ACC_STEP   12'h0C8
`define MSPC_LK_R0_0    12'h9C4
`define MSPC_LK_R0_1    12'h76C
`define MSPC_LK_R0_2    12'h5DC
`define MSPC_LK_R0_3    12'h384
`define MSPC_LK_R1_STEP 12'h190

`endif

/* File: verif/mspc_config_props.sv */
`timescale 1ns/100ps
`include "mspc_defs.vh"

// Port-level checks of the register port and the decoded settings
module mspc_config_props (
   // Clock and reset
   input wire        sys_clk,
   input wire        rst_b,
   // Register port
   input wire [7:0]  reg_addr,
   input wire        reg_wr,
   input wire [15:0] reg_wdata,
   input wire        reg_rd,
   input wire        reg_rd_valid,
   input wire        reg_miss,
   // Decoded settings
   input wire [19:0] accel2_rate,
   input wire [10:0] handover_speed,
   input wire        handover_valid,
   input wire [12:0] align_time_ms,
   input wire        overtemp_cap_en,
   input wire [11:0] accel_cap_ma,
   input wire        accel_cap_en,
   input wire [11:0] lock_cap_ma,
   input wire        closed_loop_stuck_detect_en,
   input wire        open_loop_stuck_detect_en,
   input wire        no_motor_detect_en,
   input wire        torque_const_fault_detect_en,
   input wire        speed_fault_detect_en,
   input wire        current_lock_detect_en
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // Decoded outputs lag the stored word by one cycle, so look two ahead
   wire wp  = reg_wr && reg_addr == `MSPC_ADDR_PROTECT;
   wire ws  = reg_wr && reg_addr == `MSPC_ADDR_STARTUP;
   wire hit = reg_addr == `MSPC_ADDR_PROTECT ||
              reg_addr == `MSPC_ADDR_STARTUP;
   wire [5:0] lock_en = {closed_loop_stuck_detect_en,
      open_loop_stuck_detect_en, no_motor_detect_en,
      torque_const_fault_detect_en, speed_fault_detect_en,
      current_lock_detect_en};

   property p_rd_valid;
      reg_rd |=> reg_rd_valid;
   endproperty
   a_rd_valid: assert property (p_rd_valid)
      else $error("read not answered");
   property p_miss;
      (reg_rd || reg_wr) && !hit |=> reg_miss;
   endproperty
   a_miss: assert property (p_miss)
      else $error("unmapped access not flagged");
   property p_lock_en;
      wp |-> ##2 lock_en == $past(reg_wdata[13:8], 2);
   endproperty
   a_lock_en: assert property (p_lock_en)
      else $error("detect enables wrong");
   property p_acc;
      wp |-> ##2 accel_cap_ma == $past(reg_wdata[7:4], 2) * 12'h0C8
         && accel_cap_en == ($past(reg_wdata[7:4], 2) != 4'h0);
   endproperty
   a_acc: assert property (p_acc)
      else $error("accel current cap wrong");
   property p_ot;
      wp |-> ##2 overtemp_cap_en == ($past(reg_wdata[15:14], 2) != 2'h0);
   endproperty
   a_ot: assert property (p_ot)
      else $error("overtemp cap enable wrong");
   property p_lk1;
      wp && reg_wdata[0] |-> ##2 lock_cap_ma ==
         ({9'h000, $past(reg_wdata[3:1], 2)} + 12'h001) * 12'h190;
   endproperty
   a_lk1: assert property (p_lk1)
      else $error("lock cap high range wrong");
   property p_lk0;
      wp && !reg_wdata[0] && reg_wdata[2:1] == 2'h3
         |-> ##2 lock_cap_ma == 12'h384;
   endproperty
   a_lk0: assert property (p_lk0)
      else $error("lock cap low range wrong");
   property p_hv;
      ws |-> ##2 handover_valid == ($past(reg_wdata[7:3], 2) != 5'h00);
   endproperty
   a_hv: assert property (p_hv)
      else $error("handover valid wrong");
   property p_hi;
      ws && reg_wdata[7] |-> ##2 handover_speed ==
         {$past(reg_wdata[6:3], 2), 7'h00} + 11'h077;
   endproperty
   a_hi: assert property (p_hi)
      else $error("handover high range wrong");
   property p_z2;
      ws && reg_wdata[13:11] == 3'h7 |-> ##2 accel2_rate == 20'h00000;
   endproperty
   a_z2: assert property (p_z2)
      else $error("second order not zero");
   property p_al;
      ws && reg_wdata[2:0] == 3'h7 |-> ##2 align_time_ms == 13'h0028;
   endproperty
   a_al: assert property (p_al)
      else $error("shortest align time wrong");

   // Main scenarios reached
   c_wp: cover property (wp);
   c_ws: cover property (ws);
   c_miss: cover property (reg_miss);
endmodule

bind mspc_config_top mspc_config_props u_props (
   .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rd_valid(reg_rd_valid), .reg_miss(reg_miss),
   .accel2_rate(accel2_rate), .handover_speed(handover_speed),
   .handover_valid(handover_valid), .align_time_ms(align_time_ms),
   .overtemp_cap_en(overtemp_cap_en), .accel_cap_ma(accel_cap_ma),
   .accel_cap_en(accel_cap_en), .lock_cap_ma(lock_cap_ma),
   .closed_loop_stuck_detect_en(closed_loop_stuck_detect_en),
   .open_loop_stuck_detect_en(open_loop_stuck_detect_en),
   .no_motor_detect_en(no_motor_detect_en),
   .torque_const_fault_detect_en(torque_const_fault_detect_en),
   .speed_fault_detect_en(speed_fault_detect_en),
   .current_lock_detect_en(current_lock_detect_en));

/* File: verif/mspc_config_top_bench.sv */
`timescale 1ns/100ps
`include "mspc_defs.vh"

module mspc_config_top_bench;
   reg         sys_clk;
   reg         rst_b;
   reg  [7:0]  reg_addr;
   reg         reg_wr;
   reg  [15:0] reg_wdata;
   reg         reg_rd;
   wire [15:0] reg_rdata;
   wire        reg_rd_valid;
   wire        reg_miss;
   wire [19:0] accel2_rate;
   wire [16:0] accel1_rate;
   wire [10:0] handover_speed;
   wire        handover_valid;
   wire [12:0] align_time_ms;
   wire [11:0] overtemp_cap_ma;
   wire        overtemp_cap_en;
   wire [11:0] accel_cap_ma;
   wire        accel_cap_en;
   wire [11:0] lock_cap_ma;
   wire [5:0]  lock_en;
   integer     num_errors;
   integer     n_checks;
   integer     i;
   reg  [11:0] exp_ma;

   // Expected tables, index {scale, code} for the accel ones, code alone for align and lock, entry 0 at the top
   localparam [319:0] A2_T = {`MSPC_A2_F0, `MSPC_A2_F1, `MSPC_A2_F2,
      `MSPC_A2_F3, `MSPC_A2_F4, `MSPC_A2_F5, `MSPC_A2_F6, 20'h00000,
      `MSPC_A2_S0, `MSPC_A2_S1, `MSPC_A2_S2, `MSPC_A2_S3, `MSPC_A2_S4,
      `MSPC_A2_S5, `MSPC_A2_S6, 20'h00000};
   localparam [271:0] A1_T = {`MSPC_A1_F0, `MSPC_A1_F1, `MSPC_A1_F2,
      `MSPC_A1_F3, `MSPC_A1_F4, `MSPC_A1_F5, `MSPC_A1_F6, `MSPC_A1_F7,
      `MSPC_A1_S0, `MSPC_A1_S1, `MSPC_A1_S2, `MSPC_A1_S3, `MSPC_A1_S4,
      `MSPC_A1_S5, `MSPC_A1_S6, `MSPC_A1_S7};
   localparam [103:0] AL_T = {13'h14B4, `MSPC_AL_1, `MSPC_AL_2,
      `MSPC_AL_3, `MSPC_AL_4, `MSPC_AL_5, `MSPC_AL_6, 13'h0028};
   localparam [47:0] LK_T = {12'h9C4, 12'h76C, 12'h5DC, 12'h384};

   mspc_config_top dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .reg_miss(reg_miss), .accel2_rate(accel2_rate),
      .accel1_rate(accel1_rate), .handover_speed(handover_speed),
      .handover_valid(handover_valid), .align_time_ms(align_time_ms),
      .overtemp_cap_ma(overtemp_cap_ma),
      .overtemp_cap_en(overtemp_cap_en), .accel_cap_ma(accel_cap_ma),
      .accel_cap_en(accel_cap_en), .lock_cap_ma(lock_cap_ma),
      .closed_loop_stuck_detect_en(lock_en[5]),
      .open_loop_stuck_detect_en(lock_en[4]),
      .no_motor_detect_en(lock_en[3]),
      .torque_const_fault_detect_en(lock_en[2]),
      .speed_fault_detect_en(lock_en[1]),
      .current_lock_detect_en(lock_en[0]));

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Compare and count; four-state so an unknown never matches
   task chk;
      input [19:0] got;
      input [19:0] exp;
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Write with an idle cycle after, so the decode has landed on return
   task wr;
      input [7:0]  a;
      input [15:0] d;
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         @(posedge sys_clk);
         #1;
         reg_wr = 1'b0;
         @(posedge sys_clk);
         #1;
      end
   endtask

   // Read; valid and miss only stand one cycle, so look right away
   task rd;
      input [7:0]  a;
      input [15:0] exp;
      begin
         reg_addr = a;
         reg_rd = 1'b1;
         @(posedge sys_clk);
         #1;
         reg_rd = 1'b0;
         chk(reg_rd_valid, 1'b1);
         chk(reg_miss, a != 8'h93 && a != 8'h94);
         chk(reg_rdata, exp);
         @(posedge sys_clk);
         #1;
      end
   endtask

   task summarize;
      begin
         $display("checks=%0d errors=%0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
      num_errors = 0;
      n_checks = 0;
      repeat (12) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      chk(lock_cap_ma, LK_T[47:36]);
      chk(align_time_ms, AL_T[103:91]);
      rd(8'h94, 16'h0000);
      rd(8'h93, 16'h0000);
      for (i = 0; i < 6; i = i + 1) begin
         wr(8'h94, 16'h0100 << i);
         chk(lock_en, 6'h01 << i);
      end
      // Code 00 leaves the overtemp cap off and following the accel cap
      for (i = 0; i < 16; i = i + 1) begin
         wr(8'h94, {8'h00, i[3:0], 4'h0});
         exp_ma = i[3:0] * 12'h0C8;
         chk(accel_cap_ma, exp_ma);
         chk(accel_cap_en, i != 0);
         chk(overtemp_cap_ma, exp_ma);
         chk(overtemp_cap_en, 1'b0);
      end
      for (i = 1; i < 4; i = i + 1) begin
         wr(8'h94, {i[1:0], 14'h0000});
         exp_ma = i == 1 ? 12'h3E8 : i == 2 ? 12'h640 : 12'h7D0;
         chk(overtemp_cap_ma, exp_ma);
         chk(overtemp_cap_en, 1'b1);
      end
      // Both lock cap ranges; low range ignores the top code bit
      for (i = 0; i < 16; i = i + 1) begin
         wr(8'h94, {12'h000, i[3:0]});
         exp_ma = ({9'h000, i[3:1]} + 12'h001) * 12'h190;
         if (!i[0])
            exp_ma = LK_T[47 - 12 * i[2:1] -: 12];
         chk(lock_cap_ma, exp_ma);
      end
      wr(8'h94, 16'hFFFF);
      rd(8'h94, 16'hFFFF);
      chk(lock_en, 6'h3F);
      // Same code in both accel fields and the align field
      for (i = 0; i < 16; i = i + 1) begin
         wr(8'h93, {1'b0, i[3], i[2:0], i[2:0], 5'h00, i[2:0]});
         chk(accel2_rate, A2_T[319 - 20 * i -: 20]);
         chk(accel1_rate, A1_T[271 - 17 * i -: 17]);
         chk(align_time_ms, AL_T[103 - 13 * i[2:0] -: 13]);
      end
      // Every handover code, both ranges
      for (i = 0; i < 32; i = i + 1) begin
         wr(8'h93, {8'h00, i[4:0], 3'h0});
         chk(handover_valid, i != 0);
         if (i[4])
            chk(handover_speed, {i[3:0], 7'h00} + 11'h077);
         else
            chk(handover_speed, {4'h0, i[3:0], 3'h0});
      end
      // Reserved top bit drops, unmapped write is ignored
      wr(8'h93, 16'hFFFF);
      rd(8'h93, 16'h7FFF);
      wr(8'h95, 16'h1234);
      rd(8'h95, 16'h0000);
      rd(8'h94, 16'hFFFF);
      summarize;
   end
endmodule
